// ---- pkg/lasr_pkg.sv ----
// Constants and types shared by both ends of the linear array readout link
// How it works
// - Two 128-pixel sections form one line
// - Start token walks 256 stages, one per clock
// - Controller starts cycle with captured logic 1
// - Start rising edge freezes all sampling stores
// - Token position selects pixel driven each clock
// - Integrators reset 18 clocks, integrate from 19
// - First section token out on clock 128
// - Clock 129 ends token, swaps active output
// - Second section token out on clock 256
// - Clock 257 ends second token and output
// - Next start waits transfer time after 257
// - Idle section output stays undriven
// - Serial readout 256 clocks, parallel 128
// - Second token usable for cascade or end
// - Transfer time at least 20 microseconds
// - Start pulse lasts one clock only
package lasr_pkg;
    localparam int unsigned SECTION_PIXELS      = 128;
    localparam int unsigned TOTAL_PIXELS        = 256;
    localparam int unsigned PIXEL_W             = 8;
    localparam int unsigned SEC_IDX_W           = 7;
    localparam int unsigned PIX_IDX_W           = 8;
    localparam int unsigned INTEG_RESET_CLOCKS  = 18;
    localparam int unsigned CLK_FREQ_MHZ        = 10;
    localparam int unsigned CHARGE_TRANSFER_TIME_US = 20;
    // Least time, rounded up to whole cycles
    localparam int unsigned CHARGE_TRANSFER_CYCLES =
        (CHARGE_TRANSFER_TIME_US * CLK_FREQ_MHZ + 0) > 0 ?
        (CHARGE_TRANSFER_TIME_US * CLK_FREQ_MHZ) : 1;
    localparam int unsigned WAIT_W              = 16;
    localparam int unsigned RST_CNT_W           = 5;

    // Controller sequence states
    typedef enum logic [3:0] {
        LASR_IDLE   = 4'h1,
        LASR_START  = 4'h2,
        LASR_READ   = 4'h4,
        LASR_SETTLE = 4'h8
    } lasr_state_t;

    // Position of the single set bit of a section shift register
    function automatic logic [SEC_IDX_W-1:0] lasr_onehot_idx(
        input logic [SECTION_PIXELS-1:0] vec);
        logic [SEC_IDX_W-1:0] idx;
        idx = '0;
        for (int i = 0; i < SECTION_PIXELS; i++) begin
            if (vec[i]) begin
                idx = SEC_IDX_W'(i);
            end
        end
        return idx;
    endfunction : lasr_onehot_idx
endpackage : lasr_pkg

// ---- pkg/lasr_link_if.sv ----
// Link between the readout controller and the sensor sequencer
`timescale 1ns/1ns
`default_nettype none
interface lasr_link_if
    import lasr_pkg::*;
(
    input wire logic core_clk
);
    logic               start_in_first_half;
    logic               start_in_second_half;
    logic               token_out_first_half;
    logic               token_out_second_half;
    logic [PIXEL_W-1:0] pixel_level_out_first_half;
    logic               pixel_level_out_first_half_oe_n;
    logic [PIXEL_W-1:0] pixel_level_out_second_half;
    logic               pixel_level_out_second_half_oe_n;

    modport device (
        input  start_in_first_half,
        input  start_in_second_half,
        output token_out_first_half,
        output token_out_second_half,
        output pixel_level_out_first_half,
        output pixel_level_out_first_half_oe_n,
        output pixel_level_out_second_half,
        output pixel_level_out_second_half_oe_n
    );

    modport ctrl (
        output start_in_first_half,
        output start_in_second_half,
        input  token_out_first_half,
        input  token_out_second_half,
        input  pixel_level_out_first_half,
        input  pixel_level_out_first_half_oe_n,
        input  pixel_level_out_second_half,
        input  pixel_level_out_second_half_oe_n
    );
endinterface : lasr_link_if
`default_nettype wire

// ---- core/lasr_sensor.sv ----
// Sensor end: token shift registers, hold, integrator reset, pixel output
`timescale 1ns/1ns
`default_nettype none
module lasr_sensor
    import lasr_pkg::*;
(
    // Clock, reset, enable
    input  wire logic                 core_clk,
    input  wire logic                 nrst,
    input  wire logic                 ce,
    // Link to controller
    lasr_link_if.device               link,
    // Light level loading into integrators
    input  wire logic                 light_wr,
    input  wire logic [PIX_IDX_W-1:0] light_addr,
    input  wire logic [PIXEL_W-1:0]   light_data,
    // Internal status
    output logic                      freeze_pulse,
    output logic                      integ_reset
);
    logic [SECTION_PIXELS-1:0] sr1_q, sr1_d;
    logic [SECTION_PIXELS-1:0] sr2_q, sr2_d;
    logic                      start1_prev_q;
    logic                      freeze_d, freeze_q;
    logic [RST_CNT_W-1:0]      rst_cnt_q, rst_cnt_d;
    logic                      integ_rst_q, integ_rst_d;
    logic [PIXEL_W-1:0]        pix1_q, pix1_d, pix2_q, pix2_d;
    logic                      oe1_n_q, oe1_n_d, oe2_n_q, oe2_n_d;
    logic [PIXEL_W-1:0]        integ_q [TOTAL_PIXELS];
    logic [PIXEL_W-1:0]        store_q [TOTAL_PIXELS];
    logic [PIX_IDX_W-1:0]      sel1, sel2;

    // Token shift, hold edge and reset period count
    always_comb begin
        sr1_d       = {sr1_q[SECTION_PIXELS-2:0],
                       link.start_in_first_half};
        sr2_d       = {sr2_q[SECTION_PIXELS-2:0],
                       link.start_in_second_half};
        freeze_d    = link.start_in_first_half & ~start1_prev_q;
        rst_cnt_d   = rst_cnt_q;
        if (freeze_d) begin
            rst_cnt_d = RST_CNT_W'(INTEG_RESET_CLOCKS);
        end else if (rst_cnt_q != '0) begin
            rst_cnt_d = rst_cnt_q - RST_CNT_W'(1);
        end
        integ_rst_d = (rst_cnt_d != '0);
    end

    // Pixel select and output enables; the store loads on the hold edge,
    // so the first pixel of a frame comes straight from its integrator
    always_comb begin
        sel1    = {1'b0, lasr_onehot_idx(sr1_d)};
        sel2    = {1'b1, lasr_onehot_idx(sr2_d)};
        pix1_d  = '0;
        pix2_d  = '0;
        oe1_n_d = ~|sr1_d;
        oe2_n_d = ~|sr2_d;
        if (!oe1_n_d) begin
            pix1_d = freeze_d ? integ_q[sel1] : store_q[sel1];
        end
        if (!oe2_n_d) begin
            pix2_d = freeze_d ? integ_q[sel2] : store_q[sel2];
        end
    end

    // Sequencer registers
    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            sr1_q         <= '0;
            sr2_q         <= '0;
            start1_prev_q <= 1'b0;
            freeze_q      <= 1'b0;
            rst_cnt_q     <= '0;
            integ_rst_q   <= 1'b0;
            pix1_q        <= '0;
            pix2_q        <= '0;
            oe1_n_q       <= 1'b1;
            oe2_n_q       <= 1'b1;
        end else if (ce) begin
            sr1_q         <= sr1_d;
            sr2_q         <= sr2_d;
            start1_prev_q <= link.start_in_first_half;
            freeze_q      <= freeze_d;
            rst_cnt_q     <= rst_cnt_d;
            integ_rst_q   <= integ_rst_d;
            pix1_q        <= pix1_d;
            pix2_q        <= pix2_d;
            oe1_n_q       <= oe1_n_d;
            oe2_n_q       <= oe2_n_d;
        end
    end

    // Integrators and sampling stores; stores take old charge on hold
    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            for (int i = 0; i < TOTAL_PIXELS; i++) begin
                integ_q[i] <= '0;
                store_q[i] <= '0;
            end
        end else if (ce) begin
            for (int i = 0; i < TOTAL_PIXELS; i++) begin
                if (freeze_d) begin
                    store_q[i] <= integ_q[i];
                end
                if (integ_rst_d) begin
                    integ_q[i] <= '0;
                end else if (light_wr &&
                             light_addr == PIX_IDX_W'(i)) begin
                    integ_q[i] <= light_data;
                end
            end
        end
    end

    // Link outputs
    assign link.token_out_first_half  = sr1_q[SECTION_PIXELS-1];
    assign link.token_out_second_half = sr2_q[SECTION_PIXELS-1];
    assign link.pixel_level_out_first_half       = pix1_q;
    assign link.pixel_level_out_first_half_oe_n  = oe1_n_q;
    assign link.pixel_level_out_second_half      = pix2_q;
    assign link.pixel_level_out_second_half_oe_n = oe2_n_q;
    assign freeze_pulse = freeze_q;
    assign integ_reset  = integ_rst_q;
endmodule : lasr_sensor
`default_nettype wire

// ---- core/lasr_ctrl.sv ----
// Controller end: start pulse, pixel capture, charge transfer wait
`timescale 1ns/1ns
`default_nettype none
module lasr_ctrl
    import lasr_pkg::*;
(
    // Clock, reset, enable
    input  wire logic                 core_clk,
    input  wire logic                 nrst,
    input  wire logic                 ce,
    // Link to sensor
    lasr_link_if.ctrl                 link,
    // User request
    input  wire logic                 read_req,
    input  wire logic                 parallel_mode,
    output logic                      busy,
    // User pixel stream
    output logic                      pixel_valid,
    output logic [PIX_IDX_W-1:0]      pixel_index,
    output logic [PIXEL_W-1:0]        pixel_data,
    output logic [PIXEL_W-1:0]        pixel_data_hi,
    output logic                      frame_done
);
    lasr_state_t          state_q, state_d;
    logic                 par_q, par_d;
    logic [PIX_IDX_W-1:0] idx_q, idx_d;
    logic [WAIT_W-1:0]    wait_q, wait_d;
    logic                 valid_q, valid_d, done_q, done_d;
    logic [PIXEL_W-1:0]   data_q, data_d, data_hi_q, data_hi_d;
    logic [PIX_IDX_W-1:0] oidx_q, oidx_d;
    logic                 any_out, last_seen;

    assign any_out   = ~link.pixel_level_out_first_half_oe_n |
                       ~link.pixel_level_out_second_half_oe_n;
    assign last_seen = par_q ? link.token_out_first_half
                             : link.token_out_second_half;

    // Sequence and capture next state
    always_comb begin
        state_d   = state_q;
        par_d     = par_q;
        idx_d     = idx_q;
        wait_d    = wait_q;
        valid_d   = 1'b0;
        done_d    = 1'b0;
        data_d    = data_q;
        data_hi_d = data_hi_q;
        oidx_d    = oidx_q;
        case (state_q)
            LASR_IDLE: begin
                if (read_req) begin
                    par_d   = parallel_mode;
                    state_d = LASR_START;
                end
            end
            LASR_START: begin
                idx_d   = '0;
                state_d = LASR_READ;
            end
            LASR_READ: begin
                if (any_out) begin
                    valid_d = 1'b1;
                    oidx_d  = idx_q;
                    idx_d   = idx_q + PIX_IDX_W'(1);
                    if (par_q) begin
                        data_d    = link.pixel_level_out_first_half;
                        data_hi_d = link.pixel_level_out_second_half;
                    end else if (!link.pixel_level_out_first_half_oe_n) begin
                        data_d = link.pixel_level_out_first_half;
                    end else begin
                        data_d = link.pixel_level_out_second_half;
                    end
                end
                if (last_seen) begin
                    done_d  = 1'b1;
                    wait_d  = WAIT_W'(CHARGE_TRANSFER_CYCLES);
                    state_d = LASR_SETTLE;
                end
            end
            LASR_SETTLE: begin
                if (wait_q <= WAIT_W'(1)) begin
                    wait_d  = '0;
                    state_d = LASR_IDLE;
                end else begin
                    wait_d = wait_q - WAIT_W'(1);
                end
            end
            default: begin
                state_d = LASR_IDLE;
            end
        endcase
    end

    // Controller registers
    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            state_q   <= LASR_IDLE;
            par_q     <= 1'b0;
            idx_q     <= '0;
            wait_q    <= '0;
            valid_q   <= 1'b0;
            done_q    <= 1'b0;
            data_q    <= '0;
            data_hi_q <= '0;
            oidx_q    <= '0;
        end else if (ce) begin
            state_q   <= state_d;
            par_q     <= par_d;
            idx_q     <= idx_d;
            wait_q    <= wait_d;
            valid_q   <= valid_d;
            done_q    <= done_d;
            data_q    <= data_d;
            data_hi_q <= data_hi_d;
            oidx_q    <= oidx_d;
        end
    end

    // Start drive: one clock; second section chained or shared
    assign link.start_in_first_half  = (state_q == LASR_START);
    assign link.start_in_second_half = par_q ? link.start_in_first_half
                                             : link.token_out_first_half;
    assign busy          = (state_q != LASR_IDLE);
    assign pixel_valid   = valid_q;
    assign pixel_index   = oidx_q;
    assign pixel_data    = data_q;
    assign pixel_data_hi = data_hi_q;
    assign frame_done    = done_q;
endmodule : lasr_ctrl
`default_nettype wire

// ---- dv/lasr_link_properties.sv ----
// Timing checks on the link between controller and sensor ends
`timescale 1ns/1ns
`default_nettype none
module lasr_link_properties
    import lasr_pkg::*;
(
    // Clock and reset
    input wire logic               core_clk,
    input wire logic               nrst,
    // Link signals
    input wire logic               start_in_first_half,
    input wire logic               start_in_second_half,
    input wire logic               token_out_first_half,
    input wire logic               token_out_second_half,
    input wire logic [PIXEL_W-1:0] pixel_level_out_first_half,
    input wire logic               pixel_level_out_first_half_oe_n,
    input wire logic [PIXEL_W-1:0] pixel_level_out_second_half,
    input wire logic               pixel_level_out_second_half_oe_n
);
    logic [8:0] gap_q;
    logic [8:0] gap_d;

    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!nrst);

    // Cycles since the second token was last seen, saturating
    always_comb begin
        gap_d = (gap_q == 9'h1FF) ? gap_q : gap_q + 9'h001;
        if (token_out_second_half) begin
            gap_d = 9'h000;
        end
    end

    // Gap counter register
    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            gap_q <= 9'h1FF;
        end else begin
            gap_q <= gap_d;
        end
    end

    a_tok1_at_128: assert property (start_in_first_half |-> ##128
        token_out_first_half ##1 (!token_out_first_half
        && pixel_level_out_first_half_oe_n))
        else $error("first token timing wrong");
    a_tok2_serial: assert property (start_in_first_half
        && !start_in_second_half |-> ##256 token_out_second_half ##1
        (!token_out_second_half && pixel_level_out_second_half_oe_n))
        else $error("second token timing wrong");
    a_par_both: assert property (start_in_first_half
        && start_in_second_half |-> ##128
        (token_out_first_half && token_out_second_half))
        else $error("parallel tokens not together");
    a_tok2_start: assert property (start_in_second_half |-> ##128
        token_out_second_half) else $error("second token missing");
    a_out_on: assert property (start_in_first_half |=>
        !pixel_level_out_first_half_oe_n) else $error("output not driven");
    a_idle1_hiz: assert property (pixel_level_out_first_half_oe_n |->
        pixel_level_out_first_half == '0) else $error("idle output one");
    a_idle2_hiz: assert property (pixel_level_out_second_half_oe_n |->
        pixel_level_out_second_half == '0) else $error("idle output two");
    a_start_pulse: assert property (start_in_first_half |=>
        !start_in_first_half) else $error("start longer than one cycle");
    a_tok_cause: assert property ($rose(token_out_first_half) |->
        $past(start_in_first_half, 128)) else $error("token without start");
    a_restart_gap: assert property (start_in_first_half |->
        gap_q >= 9'(CHARGE_TRANSFER_CYCLES)) else $error("restart too early");
endmodule : lasr_link_properties
`default_nettype wire

// ---- dv/lasr_tb.sv ----
// Testbench joining controller and sensor ends over the link
`timescale 1ns/1ns
`default_nettype none
module lasr_tb
    import lasr_pkg::*;
;
    logic               core_clk = 1'b0;
    logic               nrst = 1'b0;
    logic               read_req = 1'b0;
    logic               parallel_mode = 1'b0;
    logic               light_wr = 1'b0;
    logic [7:0]         light_addr = 8'h00;
    logic [7:0]         light_data = 8'h00;
    logic               busy, pixel_valid, frame_done, freeze_pulse, integ_reset;
    logic [7:0]         pixel_index, pixel_data, pixel_data_hi;
    logic [7:0]         pix_exp [256];
    int                 error_cnt = 0;
    int                 check_count = 0;

    // Clock and ends
    always #50 core_clk = ~core_clk;
    lasr_link_if i_lasr_link_if (.core_clk(core_clk));
    lasr_sensor i_lasr_sensor (.core_clk(core_clk), .nrst(nrst), .ce(1'b1),
        .link(i_lasr_link_if), .light_wr(light_wr), .light_addr(light_addr),
        .light_data(light_data), .freeze_pulse(freeze_pulse),
        .integ_reset(integ_reset));
    lasr_ctrl i_lasr_ctrl (.core_clk(core_clk), .nrst(nrst), .ce(1'b1),
        .link(i_lasr_link_if), .read_req(read_req),
        .parallel_mode(parallel_mode), .busy(busy),
        .pixel_valid(pixel_valid), .pixel_index(pixel_index),
        .pixel_data(pixel_data), .pixel_data_hi(pixel_data_hi),
        .frame_done(frame_done));
    lasr_link_properties i_lasr_link_properties (.core_clk(core_clk),
        .nrst(nrst),
        .start_in_first_half(i_lasr_link_if.start_in_first_half),
        .start_in_second_half(i_lasr_link_if.start_in_second_half),
        .token_out_first_half(i_lasr_link_if.token_out_first_half),
        .token_out_second_half(i_lasr_link_if.token_out_second_half),
        .pixel_level_out_first_half(i_lasr_link_if.pixel_level_out_first_half),
        .pixel_level_out_first_half_oe_n(
            i_lasr_link_if.pixel_level_out_first_half_oe_n),
        .pixel_level_out_second_half(
            i_lasr_link_if.pixel_level_out_second_half),
        .pixel_level_out_second_half_oe_n(
            i_lasr_link_if.pixel_level_out_second_half_oe_n));

    // Compare one value
    task automatic chk(input string what, input logic [15:0] exp,
                       input logic [15:0] got);
        check_count++;
        if (got !== exp) begin
            error_cnt++;
            $display("[ERR] %s expected %h seen %h", what, exp, got);
        end
    endtask : chk

    // Verdict and end of run
    task automatic end_sim();
        $display("checks %0d errors %0d", check_count, error_cnt);
        if (error_cnt == 0 && check_count > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask : end_sim

    // Load every integrator, key zero means leave untouched
    task automatic load(input logic [7:0] key);
        for (int i = 0; i < 256; i++) begin
            pix_exp[i] = (key == 8'h00) ? 8'h00 : (8'(i) ^ key);
            if (key != 8'h00) begin
                @(posedge core_clk);
                #1 light_wr = 1'b1;
                light_addr = 8'(i);
                light_data = 8'(i) ^ key;
            end
        end
        @(posedge core_clk);
        #1 light_wr = 1'b0;
    endtask : load

    // Request one frame and check the pixel stream
    task automatic read_frame(input logic par);
        int n;
        int ni;
        int nf;
        logic seen;
        n = 0;
        ni = 0;
        nf = 0;
        seen = 1'b0;
        @(posedge core_clk);
        #1 read_req = 1'b1;
        parallel_mode = par;
        @(posedge core_clk);
        #1 read_req = 1'b0;
        for (int c = 0; c < 700 && !seen; c++) begin
            @(posedge core_clk);
            #1;
            if (integ_reset === 1'b1) ni++;
            if (freeze_pulse === 1'b1) nf++;
            if (pixel_valid === 1'b1) begin
                chk("pixel_index", 16'(n), 16'(pixel_index));
                chk("pixel_data", 16'(pix_exp[8'(n)]), 16'(pixel_data));
                if (par) begin
                    chk("pixel_data_hi", 16'(pix_exp[8'(n + 128)]),
                        16'(pixel_data_hi));
                end
                n++;
            end
            if (frame_done === 1'b1) seen = 1'b1;
        end
        chk("valid_count", par ? 16'd128 : 16'd256, 16'(n));
        chk("frame_done", 16'd1, 16'(seen));
        chk("integ_reset_len", 16'd18, 16'(ni));
        chk("freeze_count", 16'd1, 16'(nf));
        for (int c = 0; c < 400 && busy !== 1'b0; c++) begin
            @(posedge core_clk);
            #1;
        end
        chk("busy_end", 16'd0, 16'(busy));
    endtask : read_frame

    // Main sequence
    initial begin
        repeat (12) @(posedge core_clk);
        #1 nrst = 1'b1;
        chk("oe1_n_idle", 16'd1,
            16'(i_lasr_link_if.pixel_level_out_first_half_oe_n));
        load(8'h5A);
        read_frame(1'b0);
        load(8'h00);
        read_frame(1'b0);
        load(8'hC3);
        read_frame(1'b1);
        end_sim();
    end

    // Watchdog against a hang
    initial begin
        #2000000;
        error_cnt++;
        end_sim();
    end
endmodule : lasr_tb
`default_nettype wire
